// *** design/emd_defs.vh ***
/*
  Constants for the extended memory-operation datapath: operation codes,
  flag positions, widths and fixed values.
  Assumes a single 50 MHz core clock and a sequencer that drives one
  operation request per cycle with the memory byte already fetched.
*/
// Function
// [RULE_01] Memory rotate left: bits move up, bit 7 wraps to bit 0, flags kept.
// [RULE_02] Rotate left through carry: carry into bit 0, bit 7 into carry.
// [RULE_03] Memory rotate right: bits move down, bit 0 wraps to bit 7, flags kept.
// [RULE_04] Rotate right through carry: carry into bit 7, bit 0 into carry.
// [RULE_05] Working-register forms of rotate and swap leave memory untouched.
// [RULE_06] Subtract with borrow: work minus memory minus inverted carry, to work or memory.
// [RULE_07] Plain subtract: work minus memory, to work or memory.
// [RULE_08] Subtraction clears carry on negative result, sets it otherwise.
// [RULE_09] Subtraction updates wrap, zero, half carry, carry, sign and chained zero.
// [RULE_10] Decrement memory, write back, skip when new value zero, flags kept.
// [RULE_11] Increment memory, write back, skip when new value zero, flags kept.
// [RULE_12] Work forms of decrement/increment skip write work, keep memory.
// [RULE_13] A taken skip inserts a dummy cycle, making three cycles.
// [RULE_14] Byte set writes all ones; bit set forces one bit; flags kept.
// [RULE_15] Bit test skips when the selected bit is one.
// [RULE_16] Skip-if-nonzero rewrites the byte unchanged and skips when nonzero.
// [RULE_17] Nibble exchange swaps low and high nibbles, to memory or work.
// [RULE_18] Skip-if-zero rewrites the byte unchanged and skips when zero.
// [RULE_19] Flags not affected by an operation keep their previous value.
`ifndef EMD_DEFS_VH
`define EMD_DEFS_VH

`define EMD_W 8
`define EMD_OPW 5
`define EMD_ONES 8'hff
`define EMD_ZERO 8'h00
`define EMD_ONE 8'h01
`define EMD_MSB 7
`define EMD_NIB 4

// Operation codes
`define EMD_OP_NOP 5'h00
`define EMD_OP_RL_MEM 5'h01
`define EMD_OP_RL_WORK 5'h02
`define EMD_OP_RLC_MEM 5'h03
`define EMD_OP_RLC_WORK 5'h04
`define EMD_OP_RR_MEM 5'h05
`define EMD_OP_RR_WORK 5'h06
`define EMD_OP_RRC_MEM 5'h07
`define EMD_OP_RRC_WORK 5'h08
`define EMD_OP_SBC_WORK 5'h09
`define EMD_OP_SBC_MEM 5'h0a
`define EMD_OP_SUB_WORK 5'h0b
`define EMD_OP_SUB_MEM 5'h0c
`define EMD_OP_DSZ_MEM 5'h0d
`define EMD_OP_DSZ_WORK 5'h0e
`define EMD_OP_ISZ_MEM 5'h0f
`define EMD_OP_ISZ_WORK 5'h10
`define EMD_OP_SET_BYTE 5'h11
`define EMD_OP_SET_BIT 5'h12
`define EMD_OP_SNZ_BIT 5'h13
`define EMD_OP_SNZ_BYTE 5'h14
`define EMD_OP_SWAP_MEM 5'h15
`define EMD_OP_SWAP_WORK 5'h16
`define EMD_OP_SZ_BYTE 5'h17

// Flag vector positions
`define EMD_FW 6
`define EMD_F_C 0
`define EMD_F_AC 1
`define EMD_F_Z 2
`define EMD_F_OV 3
`define EMD_F_SC 4
`define EMD_F_CZ 5
`define EMD_FLAGS_RST 6'h00

`endif

// *** design/emd_datapath.v ***
/*
  Extended memory-operation datapath. Takes one request with the memory
  operand, working register and flags; one cycle later presents the
  results registered: memory write, working register write, flags, skip.
  Assumes the sequencer applies the results and, on a skip, inserts the
  dummy fetch while o_busy is high for one extra cycle.
*/
`timescale 1ns/1ns
`default_nettype none
`include "emd_defs.vh"

module emd_datapath (
  input wire i_mclk,
  input wire i_rst_n,
  input wire i_req,
  input wire [`EMD_OPW-1:0] i_op,
  input wire [2:0] i_bit_sel,
  input wire [`EMD_W-1:0] i_mem_rdata,
  input wire [`EMD_W-1:0] i_working_register,
  input wire [`EMD_FW-1:0] i_flags,
  output reg o_done,
  output reg o_mem_we,
  output reg [`EMD_W-1:0] o_mem_wdata,
  output reg o_work_we,
  output reg [`EMD_W-1:0] o_work_wdata,
  output reg o_flags_we,
  output reg [`EMD_FW-1:0] o_flags,
  output reg o_skip,
  output reg o_busy
);

  // ==========================================================
  // Operand shaping
  // ==========================================================
  wire [`EMD_W-1:0] m = i_mem_rdata;
  wire [`EMD_W-1:0] a = i_working_register;
  wire c_in = i_flags[`EMD_F_C];
  wire z_in = i_flags[`EMD_F_Z];
  wire [`EMD_W-1:0] rl = {m[`EMD_MSB-1:0], m[`EMD_MSB]}; // [RULE_01]
  wire [`EMD_W-1:0] rlc = {m[`EMD_MSB-1:0], c_in}; // [RULE_02]
  wire [`EMD_W-1:0] rr = {m[0], m[`EMD_MSB:1]}; // [RULE_03]
  wire [`EMD_W-1:0] rrc = {c_in, m[`EMD_MSB:1]}; // [RULE_04]
  wire [`EMD_W-1:0] swp = {m[`EMD_NIB-1:0], m[`EMD_W-1:`EMD_NIB]}; // [RULE_17]
  wire [`EMD_W-1:0] dec = m - `EMD_ONE; // [RULE_10]
  wire [`EMD_W-1:0] inc = m + `EMD_ONE; // [RULE_11]

  // Bit mask built per bit so the selected position is a plain decode
  wire [`EMD_W-1:0] bmask;
  genvar g;
  generate
    for (g = 0; g < `EMD_W; g = g + 1) begin : g_mask
      assign bmask[g] = (i_bit_sel == g);
    end
  endgenerate

  // ==========================================================
  // Subtractor
  // ==========================================================
  // Borrow-in only for the borrow forms; carry out is the not-borrow
  wire is_sbc = (i_op == `EMD_OP_SBC_WORK) || (i_op == `EMD_OP_SBC_MEM);
  wire bin = is_sbc & ~c_in; // [RULE_06]
  wire [`EMD_W:0] diff = {1'b0, a} + {1'b0, ~m} + {8'h00, ~bin}; // [RULE_06] [RULE_07]
  wire [`EMD_NIB:0] ldiff = {1'b0, a[`EMD_NIB-1:0]} + {1'b0, ~m[`EMD_NIB-1:0]}
                            + {4'h0, ~bin};
  wire [`EMD_W-1:0] res = diff[`EMD_W-1:0];
  wire res_z = (res == `EMD_ZERO);
  wire ov = (a[`EMD_MSB] ^ m[`EMD_MSB]) & (a[`EMD_MSB] ^ res[`EMD_MSB]);
  // For the borrow forms, chained zero only stays set if the previous stage was also zero
  wire cz = is_sbc ? (res_z & z_in) : res_z;
  wire [`EMD_FW-1:0] sub_flags;
  assign sub_flags[`EMD_F_C] = diff[`EMD_W]; // [RULE_08]
  assign sub_flags[`EMD_F_AC] = ldiff[`EMD_NIB];
  assign sub_flags[`EMD_F_Z] = res_z;
  assign sub_flags[`EMD_F_OV] = ov;
  assign sub_flags[`EMD_F_SC] = res[`EMD_MSB] ^ ov;
  assign sub_flags[`EMD_F_CZ] = cz;

  // ==========================================================
  // Result selection
  // ==========================================================
  reg mem_we_d;
  reg [`EMD_W-1:0] mem_wdata_d;
  reg work_we_d;
  reg [`EMD_W-1:0] work_wdata_d;
  reg flags_we_d;
  reg [`EMD_FW-1:0] flags_d;
  reg skip_d;

  always @* begin
    mem_we_d = 1'b0;
    mem_wdata_d = m;
    work_we_d = 1'b0;
    work_wdata_d = a;
    flags_we_d = 1'b0;
    flags_d = i_flags; // [RULE_19]
    skip_d = 1'b0;
    case (i_op)
      `EMD_OP_RL_MEM: begin
        mem_we_d = 1'b1;
        mem_wdata_d = rl; // [RULE_01]
      end
      `EMD_OP_RL_WORK: begin
        work_we_d = 1'b1;
        work_wdata_d = rl; // [RULE_05]
      end
      `EMD_OP_RLC_MEM: begin
        mem_we_d = 1'b1;
        mem_wdata_d = rlc;
        flags_we_d = 1'b1;
        flags_d[`EMD_F_C] = m[`EMD_MSB]; // [RULE_02]
      end
      `EMD_OP_RLC_WORK: begin
        work_we_d = 1'b1;
        work_wdata_d = rlc; // [RULE_05]
        flags_we_d = 1'b1;
        flags_d[`EMD_F_C] = m[`EMD_MSB]; // [RULE_02]
      end
      `EMD_OP_RR_MEM: begin
        mem_we_d = 1'b1;
        mem_wdata_d = rr; // [RULE_03]
      end
      `EMD_OP_RR_WORK: begin
        work_we_d = 1'b1;
        work_wdata_d = rr; // [RULE_05]
      end
      `EMD_OP_RRC_MEM: begin
        mem_we_d = 1'b1;
        mem_wdata_d = rrc;
        flags_we_d = 1'b1;
        flags_d[`EMD_F_C] = m[0]; // [RULE_04]
      end
      `EMD_OP_RRC_WORK: begin
        work_we_d = 1'b1;
        work_wdata_d = rrc; // [RULE_05]
        flags_we_d = 1'b1;
        flags_d[`EMD_F_C] = m[0]; // [RULE_04]
      end
      `EMD_OP_SBC_WORK, `EMD_OP_SUB_WORK: begin
        work_we_d = 1'b1;
        work_wdata_d = res; // [RULE_06] [RULE_07]
        flags_we_d = 1'b1;
        flags_d = sub_flags; // [RULE_09]
      end
      `EMD_OP_SBC_MEM, `EMD_OP_SUB_MEM: begin
        mem_we_d = 1'b1;
        mem_wdata_d = res; // [RULE_06] [RULE_07]
        flags_we_d = 1'b1;
        flags_d = sub_flags; // [RULE_09]
      end
      `EMD_OP_DSZ_MEM: begin
        mem_we_d = 1'b1;
        mem_wdata_d = dec;
        skip_d = (dec == `EMD_ZERO); // [RULE_10]
      end
      `EMD_OP_DSZ_WORK: begin
        work_we_d = 1'b1;
        work_wdata_d = dec;
        skip_d = (dec == `EMD_ZERO); // [RULE_12]
      end
      `EMD_OP_ISZ_MEM: begin
        mem_we_d = 1'b1;
        mem_wdata_d = inc;
        skip_d = (inc == `EMD_ZERO); // [RULE_11]
      end
      `EMD_OP_ISZ_WORK: begin
        work_we_d = 1'b1;
        work_wdata_d = inc;
        skip_d = (inc == `EMD_ZERO); // [RULE_12]
      end
      `EMD_OP_SET_BYTE: begin
        mem_we_d = 1'b1;
        mem_wdata_d = `EMD_ONES; // [RULE_14]
      end
      `EMD_OP_SET_BIT: begin
        mem_we_d = 1'b1;
        mem_wdata_d = m | bmask; // [RULE_14]
      end
      `EMD_OP_SNZ_BIT: begin
        skip_d = |(m & bmask); // [RULE_15]
      end
      `EMD_OP_SNZ_BYTE: begin
        mem_we_d = 1'b1;
        mem_wdata_d = m;
        skip_d = (m != `EMD_ZERO); // [RULE_16]
      end
      `EMD_OP_SWAP_MEM: begin
        mem_we_d = 1'b1;
        mem_wdata_d = swp; // [RULE_17]
      end
      `EMD_OP_SWAP_WORK: begin
        work_we_d = 1'b1;
        work_wdata_d = swp; // [RULE_05] [RULE_17]
      end
      `EMD_OP_SZ_BYTE: begin
        mem_we_d = 1'b1;
        mem_wdata_d = m;
        skip_d = (m == `EMD_ZERO); // [RULE_18]
      end
      default: begin
        skip_d = 1'b0;
      end
    endcase
  end

  // ==========================================================
  // Output registers
  // ==========================================================
  // Writes are gated by the request so a stale opcode never disturbs state
  always @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_done <= 1'b0;
      o_mem_we <= 1'b0;
      o_mem_wdata <= `EMD_ZERO;
      o_work_we <= 1'b0;
      o_work_wdata <= `EMD_ZERO;
      o_flags_we <= 1'b0;
      o_flags <= `EMD_FLAGS_RST;
      o_skip <= 1'b0;
      o_busy <= 1'b0;
    end else begin
      o_done <= i_req;
      o_mem_we <= i_req & mem_we_d;
      o_mem_wdata <= mem_wdata_d;
      o_work_we <= i_req & work_we_d;
      o_work_wdata <= work_wdata_d;
      o_flags_we <= i_req & flags_we_d;
      o_flags <= flags_d;
      o_skip <= i_req & skip_d;
      o_busy <= i_req & skip_d; // [RULE_13]
    end
  end

endmodule
`default_nettype wire

// *** testbench/emd_datapath_props.sv ***
/* Port checker for emd_datapath.
   Assumes emd_defs.vh on the include path. */
`timescale 1ns/1ns
`default_nettype none
`include "emd_defs.vh"
// ====
// Checker
module emd_datapath_props (
  input wire logic i_mclk,
  input wire logic i_rst_n,
  input wire logic i_req,
  input wire logic [4:0] i_op,
  input wire logic [7:0] i_mem_rdata,
  input wire logic [7:0] i_working_register,
  input wire logic [5:0] i_flags,
  input wire logic o_mem_we,
  input wire logic [7:0] o_mem_wdata,
  input wire logic o_work_we,
  input wire logic [7:0] o_work_wdata,
  input wire logic o_flags_we,
  input wire logic [5:0] o_flags,
  input wire logic o_skip,
  input wire logic o_busy
);
  default clocking @(posedge i_mclk); endclocking
  default disable iff (!i_rst_n);
  sequence s_op(logic [4:0] c);
    i_req && i_op == c;
  endsequence
  sequence s_mem;
    o_mem_we && !o_work_we;
  endsequence
  chk_rl_mem: assert property (s_op(`EMD_OP_RL_MEM) |=> s_mem ##0 (!o_flags_we &&
    {o_mem_wdata[0], o_mem_wdata[7:1]} == $past(i_mem_rdata))) else $error("rl bad");
  chk_rlc_carry: assert property (s_op(`EMD_OP_RLC_MEM) |=> s_mem ##0
    ({o_flags[0], o_mem_wdata, o_flags[5:1]} ==
    {$past(i_mem_rdata), $past(i_flags[0]), $past(i_flags[5:1])})
    ) else $error("rlc bad");
  chk_rr_work: assert property (s_op(`EMD_OP_RR_WORK) |=> o_work_we && !o_mem_we &&
    {o_work_wdata[6:0], o_work_wdata[7]} == $past(i_mem_rdata)) else $error("rr bad");
  chk_rrc_carry: assert property (s_op(`EMD_OP_RRC_MEM) |=> s_mem ##0
    ({o_mem_wdata[6:0], o_flags[0], o_flags[5:1], o_mem_wdata[7]} ==
    {$past(i_mem_rdata), $past(i_flags)})) else $error("rrc bad");
  chk_dsz_skip: assert property (s_op(`EMD_OP_DSZ_MEM) |=> s_mem ##0
    (o_mem_wdata == $past(i_mem_rdata) - 8'h01 && o_skip == (o_mem_wdata == 8'h00)))
    else $error("dsz bad");
  chk_set_byte: assert property (s_op(`EMD_OP_SET_BYTE) |=> s_mem ##0
    (o_mem_wdata == 8'hff && !o_flags_we)) else $error("set bad");
  chk_swap_work: assert property (s_op(`EMD_OP_SWAP_WORK) |=> o_work_we && !o_mem_we &&
    {o_work_wdata[3:0], o_work_wdata[7:4]} == $past(i_mem_rdata)) else $error("swap bad");
  chk_dummy_slot: assert property (o_busy == o_skip) else $error("busy bad");
  chk_zero_skip: assert property (s_op(`EMD_OP_SZ_BYTE) |=>
    o_busy == ($past(i_mem_rdata) == 8'h00)) else $error("sz bad");
  chk_sub_carry: assert property (s_op(`EMD_OP_SUB_WORK) |=> o_flags_we &&
    o_flags[0] == ($past(i_working_register) >= $past(i_mem_rdata))) else $error("sub bad");
endmodule
bind emd_datapath emd_datapath_props u_props (.*);
`default_nettype wire

// *** testbench/emd_seq_model.sv ***
/* Sequencer and data memory model for emd_datapath.
   Assumes results arrive one cycle after each request. */
`timescale 1ns/1ns
`default_nettype none
// ====
// Far side
module emd_seq_model (
  input wire logic i_mclk,
  input wire logic i_rst_n,
  input wire logic i_mem_we,
  input wire logic [7:0] i_mem_wd,
  input wire logic i_work_we,
  input wire logic [7:0] i_work_wd,
  input wire logic i_flags_we,
  input wire logic [5:0] i_flags_wd,
  output logic [7:0] o_mem,
  output logic [7:0] o_work,
  output logic [5:0] o_flags
);
  // Writebacks feed later operands, so state walks without reloads
  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      {o_mem, o_work, o_flags} <= 22'h0;
    end else begin
      if (i_mem_we) o_mem <= i_mem_wd;
      if (i_work_we) o_work <= i_work_wd;
      if (i_flags_we) o_flags <= i_flags_wd;
    end
  end
endmodule
`default_nettype wire

// *** testbench/tb_emd_datapath.sv ***
/* Random bench for emd_datapath; each request queues its expected result.
   Assumes the far-side model holds memory, working register and flags. */
`timescale 1ns/1ns
`default_nettype none
`include "emd_defs.vh"
// ====
// Bench
module tb_emd_datapath;
  logic i_mclk = 1'b0;
  logic i_rst_n = 1'b0;
  logic i_req = 1'b0;
  logic [4:0] i_op = 5'h00;
  logic [2:0] i_bit_sel = 3'h0;
  logic [26:0] e;
  logic [25:0] g;
  logic [26:0] q[$];
  wire o_done, o_mem_we, o_work_we, o_flags_we, o_skip, o_busy;
  wire [7:0] i_mem_rdata, i_working_register, o_mem_wdata, o_work_wdata;
  wire [5:0] i_flags, o_flags;
  int miscompares = 0;
  int check_count = 0;
  always #10 i_mclk = ~i_mclk;
  emd_datapath dut (.*);
  emd_seq_model far (.i_mclk, .i_rst_n, .i_mem_we(o_mem_we), .i_mem_wd(o_mem_wdata),
    .i_work_we(o_work_we), .i_work_wd(o_work_wdata), .i_flags_we(o_flags_we),
    .i_flags_wd(o_flags), .o_mem(i_mem_rdata), .o_work(i_working_register), .o_flags(i_flags));
  // Top bit marks results modelled here; every opcode, undefined ones included, sets it
  function automatic logic [26:0] expect_of(logic [4:0] o, logic [7:0] m, a, logic [5:0] f,
      logic [2:0] b);
    logic [8:0] mw, ww, d;
    logic [6:0] fw;
    logic [4:0] h;
    logic sk, su, sb, z, wr, kn;
    {mw, ww, fw, sk, su} = 27'h0;
    kn = 1'b1;
    sb = o == `EMD_OP_SBC_WORK || o == `EMD_OP_SBC_MEM;
    d = {1'b0, a} - {1'b0, m} - {8'h00, sb & ~f[0]};
    h = {1'b0, a[3:0]} - {1'b0, m[3:0]} - {4'h0, sb & ~f[0]};
    z = d[7:0] == 8'h00;
    wr = (a[7] ^ m[7]) & (a[7] ^ d[7]);
    case (o)
      `EMD_OP_RL_MEM: mw = {1'b1, m[6:0], m[7]};
      `EMD_OP_RL_WORK: ww = {1'b1, m[6:0], m[7]};
      `EMD_OP_RLC_MEM: {mw, fw} = {1'b1, m[6:0], f[0], 1'b1, f[5:1], m[7]};
      `EMD_OP_RLC_WORK: {ww, fw} = {1'b1, m[6:0], f[0], 1'b1, f[5:1], m[7]};
      `EMD_OP_RR_MEM: mw = {1'b1, m[0], m[7:1]};
      `EMD_OP_RR_WORK: ww = {1'b1, m[0], m[7:1]};
      `EMD_OP_RRC_MEM: {mw, fw} = {1'b1, f[0], m[7:1], 1'b1, f[5:1], m[0]};
      `EMD_OP_RRC_WORK: {ww, fw} = {1'b1, f[0], m[7:1], 1'b1, f[5:1], m[0]};
      `EMD_OP_SET_BYTE: mw = {1'b1, 8'hff};
      `EMD_OP_SWAP_MEM: mw = {1'b1, m[3:0], m[7:4]};
      `EMD_OP_SWAP_WORK: ww = {1'b1, m[3:0], m[7:4]};
      `EMD_OP_SBC_WORK, `EMD_OP_SUB_WORK: {ww, su} = {1'b1, d[7:0], 1'b1};
      `EMD_OP_SBC_MEM, `EMD_OP_SUB_MEM: {mw, su} = {1'b1, d[7:0], 1'b1};
      `EMD_OP_DSZ_MEM: {mw, sk} = {1'b1, m - 8'h01, m == 8'h01};
      `EMD_OP_DSZ_WORK: {ww, sk} = {1'b1, m - 8'h01, m == 8'h01};
      `EMD_OP_ISZ_MEM: {mw, sk} = {1'b1, m + 8'h01, m == 8'hff};
      `EMD_OP_ISZ_WORK: {ww, sk} = {1'b1, m + 8'h01, m == 8'hff};
      `EMD_OP_SET_BIT: mw = {1'b1, m | (8'h01 << b)};
      `EMD_OP_SNZ_BIT: sk = m[b];
      `EMD_OP_SNZ_BYTE: {mw, sk} = {1'b1, m, m != 8'h00};
      `EMD_OP_SZ_BYTE: {mw, sk} = {1'b1, m, m == 8'h00};
      `EMD_OP_NOP: sk = 1'b0;
      default: kn = o > `EMD_OP_SZ_BYTE;
    endcase
    if (su) fw = {1'b1, z & (f[2] | ~sb), d[7] ^ wr, wr, z, ~h[4], ~d[8]};
    return {kn, mw, ww, fw, sk};
  endfunction
  task automatic compare(input logic [25:0] exp, input logic [25:0] got);
    check_count++;
    if (got !== exp) begin
      miscompares++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic test_done();
    if (miscompares == 0 && check_count > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  always @(negedge i_mclk) begin
    if (o_done === 1'b1) begin
      e = q.size() > 0 ? q.pop_front() : 27'h7ffffff;
      g = {o_mem_we, o_mem_we ? o_mem_wdata : 8'h00, o_work_we, o_work_we ? o_work_wdata : 8'h00,
        o_flags_we, o_flags_we ? o_flags : 6'h00, o_skip};
      if (e[26]) compare(e[25:0], g);
    end
  end
  initial begin
    void'($urandom(32'h133c));
    repeat (10) @(negedge i_mclk);
    i_rst_n = 1'b1;
    repeat (3000) begin
      @(negedge i_mclk);
      i_req = $urandom_range(3) != 0;
      i_op = 5'($urandom_range(31));
      i_bit_sel = 3'($urandom);
      if (i_req)
        q.push_back(expect_of(i_op, i_mem_rdata, i_working_register, i_flags, i_bit_sel));
    end
    @(negedge i_mclk);
    i_req = 1'b0;
    repeat (2) @(negedge i_mclk);
    test_done();
  end
  initial begin
    #80000;
    miscompares++;
    test_done();
  end
endmodule
`default_nettype wire
